/* File: common/i2c_ctl_defines.vh */
// Constants for the two-wire master control block
`ifndef I2C_CTL_DEFINES_VH
`define I2C_CTL_DEFINES_VH

// Bits per byte on the wire
`define I2C_BITS_PER_BYTE 4'h8
// Index of the last quarter phase of a bit cell
`define I2C_LAST_PHASE    2'h3
// Filter latency in system clocks, pin to filtered line
`define I2C_FILTER_LAT    3
// Reset value of the baud counter
`define I2C_BRG_RST       16'h0000
// Reset value of the data register
`define I2C_DATA_RST      8'h00
// Line index of the pin pair
`define I2C_SDA_IDX       0
`define I2C_SCL_IDX       1

`endif

/* File: verification/i2c_ctl_monitor.sv */
// Checker of request bits, flags and baud timer pulses of the two-wire master
`default_nettype none
module i2c_ctl_monitor #(
    parameter BRG_W = 16
) (
    input wire logic             ref_clk,
    input wire logic             rst_b,
    input wire logic             clk_en,
    input wire logic             controller_enable,
    input wire logic             flush_cmd,
    input wire logic             data_wr,
    input wire logic             brg_counter_irq_enable,
    input wire logic             tx_empty_irq_enable,
    input wire logic [BRG_W-1:0] brg_reload,
    input wire logic             sda_oe_r,
    input wire logic             scl_oe_r,
    input wire logic             start_pending_r,
    input wire logic             stop_pending_r,
    input wire logic             nak_pending_r,
    input wire logic             flush_readback_r,
    input wire logic             tx_data_empty_flag_r,
    input wire logic             tx_empty_irq_r,
    input wire logic             brg_irq_r,
    input wire logic             bus_busy_r
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    logic [BRG_W:0] gap_r;
    logic           seen_r;
    // Gap is only trusted once a pulse was seen with a steady reload value
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            gap_r  <= '0;
            seen_r <= 1'b0;
        end else if (clk_en) begin
            if (brg_irq_r) gap_r <= 1;
            else if (gap_r != '1) gap_r <= gap_r + 1'b1;
            if (!brg_counter_irq_enable || $changed(brg_reload)) seen_r <= 1'b0;
            else if (brg_irq_r) seen_r <= 1'b1;
        end
    end
    a_flush_reads_zero: assert property (!flush_readback_r)
        else $error("flush readback not zero");
    a_flush_empties: assert property (flush_cmd && !data_wr && clk_en |=> tx_data_empty_flag_r)
        else $error("flush did not set empty flag");
    a_load_fills: assert property (data_wr && clk_en |=> !tx_data_empty_flag_r)
        else $error("load did not clear empty flag");
    a_disable_clears: assert property (!controller_enable && clk_en |=> !(start_pending_r || stop_pending_r || nak_pending_r))
        else $error("disable left a request pending");
    a_start_clear_cause: assert property ($fell(start_pending_r) && $past(controller_enable) |-> sda_oe_r)
        else $error("start request cleared without start on bus");
    a_stop_clear_cause: assert property ($fell(stop_pending_r) && $past(controller_enable) |-> !sda_oe_r && !scl_oe_r)
        else $error("stop request cleared before lines released");
    a_start_needs_data: assert property ($rose(bus_busy_r) |-> !tx_data_empty_flag_r)
        else $error("start issued with no byte loaded");
    a_empty_irq_level: assert property ($past(rst_b) && $past(clk_en) |-> tx_empty_irq_r == $past(tx_empty_irq_enable && controller_enable && tx_data_empty_flag_r))
        else $error("transmit empty request wrong");
    a_brg_period: assert property (brg_irq_r && seen_r |-> gap_r == {1'b0, brg_reload} + 1'b1)
        else $error("baud timer pulse spacing wrong");
    a_brg_needs_enable: assert property (brg_irq_r |-> $past(brg_counter_irq_enable))
        else $error("baud timer pulse while disabled");
    a_nak_released: assert property ($fell(nak_pending_r) && $past(controller_enable) |-> !sda_oe_r)
        else $error("not-acknowledge cleared with data line pulled");
endmodule // i2c_ctl_monitor
bind i2c_master_control_bits i2c_ctl_monitor #(.BRG_W(BRG_W)) i_i2c_ctl_monitor (
    .ref_clk, .rst_b, .clk_en, .controller_enable, .flush_cmd, .data_wr,
    .brg_counter_irq_enable, .tx_empty_irq_enable, .brg_reload, .sda_oe_r, .scl_oe_r,
    .start_pending_r, .stop_pending_r, .nak_pending_r, .flush_readback_r,
    .tx_data_empty_flag_r, .tx_empty_irq_r, .brg_irq_r, .bus_busy_r);
`default_nettype wire

/* File: verification/i2c_slave_model.sv */
// Behavioural two-wire slave: acks writes, serves one byte on reads, may stretch clock
`default_nettype none
module i2c_slave_model (
    input  wire logic       ref_clk,
    input  wire logic       rst_b,
    input  wire logic       sda,
    input  wire logic       scl,
    input  wire logic       rd_mode,
    input  wire logic [7:0] rd_byte,
    input  wire logic [7:0] stretch,
    output var  logic       sda_hold,
    output wire logic       scl_hold,
    output var  logic [7:0] got_byte,
    output var  logic       rd_now,
    output var  logic       mst_ack
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] bitcnt;
    logic [7:0] sh;
    logic [7:0] hold_cnt;
    logic       sda_q;
    logic       scl_q;
    assign scl_hold = hold_cnt != 8'h00;
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            {sda_q, scl_q, sda_hold, rd_now, mst_ack} <= 5'h18;
            bitcnt   <= 4'hF;
            sh       <= 8'h00;
            got_byte <= 8'h00;
            hold_cnt <= 8'h00;
        end else begin
            sda_q <= sda;
            scl_q <= scl;
            if (hold_cnt != 8'h00) hold_cnt <= hold_cnt - 8'h01;
            if (scl && scl_q && sda_q != sda) begin
                // Start or stop; the start's own clock fall wraps the count to 0
                bitcnt   <= 4'hF;
                sda_hold <= 1'b0;
                rd_now   <= 1'b0;
            end else if (scl && !scl_q) begin
                if (bitcnt < 4'h8) sh <= {sh[6:0], sda};
                if (bitcnt == 4'h8 && rd_now) mst_ack <= sda;
            end else if (!scl && scl_q) begin
                hold_cnt <= stretch;
                bitcnt   <= (bitcnt == 4'h8) ? 4'h0 : bitcnt + 4'h1;
                if (bitcnt == 4'h8) begin
                    rd_now   <= rd_mode;
                    sda_hold <= rd_mode && !rd_byte[7];
                end else if (bitcnt == 4'h7) begin
                    got_byte <= sh;
                    sda_hold <= !rd_now;
                end else if (bitcnt < 4'h7) begin
                    sda_hold <= rd_now && !rd_byte[3'h6 - bitcnt[2:0]];
                end
            end
        end
    end
endmodule // i2c_slave_model
`default_nettype wire

/* File: verification/testbench.sv */
// Self-checking bench for the two-wire master control bits
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [4:0] ST = 5'h01, SP = 5'h02, NK = 5'h04, FL = 5'h08, DW = 5'h10;
    localparam logic [7:0] RD_BYTE = 8'hC6;
    logic        ref_clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        clk_en = 1'b1;
    logic        controller_enable = 1'b0;
    logic        brg_counter_irq_enable = 1'b0;
    logic        tx_empty_irq_enable = 1'b0;
    logic        input_glitch_filter_enable = 1'b0;
    logic        receive_mode = 1'b0;
    logic [15:0] brg_reload = 16'h0001;
    logic [7:0]  data_in = 8'h00;
    logic [7:0]  stretch = 8'h00;
    logic [4:0]  strb = 5'h00;
    wire         start_set, stop_set, nak_set, flush_cmd, data_wr, sda_out_r, scl_out_r;
    wire         sda_oe_r, scl_oe_r, start_pending_r, stop_pending_r, nak_pending_r;
    wire         flush_readback_r, tx_data_empty_flag_r, tx_empty_irq_r, brg_irq_r;
    wire         rx_valid_r, bus_busy_r, sda_hold, scl_hold, rd_now, mst_ack, ack_missing_r;
    wire  [7:0]  rx_data_r, got_byte;
    wire         sda_in = ~(sda_oe_r | sda_hold);
    wire         scl_in = ~(scl_oe_r | scl_hold);
    int          failures = 0, checks_done = 0, cycles = 0, irq_cnt;
    assign {data_wr, flush_cmd, nak_set, stop_set, start_set} = strb;
    always #4 ref_clk = ~ref_clk;
    i2c_master_control_bits #(.BRG_W(16)) i_i2c_master_control_bits (
        .ref_clk, .rst_b, .clk_en, .controller_enable, .start_set, .stop_set, .nak_set,
        .flush_cmd, .brg_counter_irq_enable, .tx_empty_irq_enable, .input_glitch_filter_enable,
        .receive_mode, .brg_reload, .data_wr, .data_in, .sda_in, .scl_in, .sda_out_r,
        .sda_oe_r, .scl_out_r, .scl_oe_r, .start_pending_r, .stop_pending_r, .nak_pending_r,
        .flush_readback_r, .tx_data_empty_flag_r, .tx_empty_irq_r, .brg_irq_r, .rx_data_r,
        .rx_valid_r, .ack_missing_r, .bus_busy_r);
    i2c_slave_model i_i2c_slave_model (
        .ref_clk, .rst_b, .sda(sda_in), .scl(scl_in), .rd_mode(receive_mode),
        .rd_byte(RD_BYTE), .stretch, .sda_hold, .scl_hold, .got_byte, .rd_now, .mst_ack);
    task automatic stop_test;
        if (failures == 0 && checks_done > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic pulse(input logic [4:0] m, input logic [7:0] d);
        @(posedge ref_clk);
        strb    <= m;
        data_in <= d;
        @(posedge ref_clk);
        strb <= 5'h00;
    endtask
    function automatic logic pick(input int sel);
        case (sel)
            0: return start_pending_r;
            1: return bus_busy_r;
            2: return rx_valid_r;
            default: return rd_now;
        endcase
    endfunction
    // Bounded so a stuck handshake ends as a mismatch, not a hang
    task automatic wait_for(input int sel, input logic val);
        int n;
        n = 0;
        @(negedge ref_clk);
        while (pick(sel) !== val && n < 3000) begin
            @(negedge ref_clk);
            n++;
        end
        check("wait_done", {7'h00, n == 3000}, 8'h00);
    endtask
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            stop_test();
        end
    end
    initial begin
        repeat (20) @(posedge ref_clk);
        rst_b <= 1'b1;
        @(negedge ref_clk);
        check("reset_state", {tx_data_empty_flag_r, flush_readback_r, sda_oe_r}, 8'h04);
        pulse(ST | SP | NK, 8'h00);
        @(negedge ref_clk);
        check("req_refused", {start_pending_r, stop_pending_r, nak_pending_r}, 8'h00);
        @(posedge ref_clk);
        controller_enable <= 1'b1;
        pulse(ST | SP | NK, 8'h00);
        repeat (40) @(negedge ref_clk);
        check("req_held", {bus_busy_r, start_pending_r, stop_pending_r, nak_pending_r}, 8'h07);
        @(posedge ref_clk);
        controller_enable <= 1'b0;
        repeat (2) @(negedge ref_clk);
        check("req_cleared", {start_pending_r, stop_pending_r, nak_pending_r}, 8'h00);
        @(posedge ref_clk);
        controller_enable <= 1'b1;
        for (int p = 0; p < 2; p++) begin
            @(posedge ref_clk);
            input_glitch_filter_enable <= p[0];
            stretch <= p[0] ? 8'h03 : 8'h00;
            pulse(DW, 8'h11 ^ {7'h00, p[0]});
            @(negedge ref_clk);
            check("flag_load", tx_data_empty_flag_r, 8'h00);
            pulse(ST, 8'h00);
            wait_for(0, 1'b0);
            check("flag_moved", tx_data_empty_flag_r, 8'h01);
            pulse(DW, 8'h5A);
            pulse(ST, 8'h5A);
            wait_for(0, 1'b0);
            check("byte_before_restart", got_byte, 8'h11 ^ {7'h00, p[0]});
            pulse(DW, 8'hC3);
            pulse(SP | ST, 8'hC3);
            wait_for(1, 1'b0);
            check("stop_then_start", {stop_pending_r, start_pending_r}, 8'h01);
            check("byte_before_stop", got_byte, 8'h5A);
            wait_for(0, 1'b0);
            pulse(SP, 8'h00);
            wait_for(1, 1'b0);
            check("last_byte", {got_byte}, 8'hC3);
            check("line_idle", {stop_pending_r, ack_missing_r, sda_out_r, scl_out_r}, 8'h00);
        end
        @(posedge ref_clk);
        tx_empty_irq_enable <= 1'b1;
        repeat (2) @(negedge ref_clk);
        check("irq_empty", tx_empty_irq_r, 8'h01);
        pulse(DW, 8'h55);
        repeat (2) @(negedge ref_clk);
        check("irq_full", {tx_empty_irq_r, tx_data_empty_flag_r}, 8'h00);
        pulse(FL, 8'h00);
        repeat (2) @(negedge ref_clk);
        check("flush", {tx_empty_irq_r, tx_data_empty_flag_r, flush_readback_r}, 8'h06);
        pulse(DW, 8'hA1);
        pulse(ST, 8'hA1);
        wait_for(0, 1'b0);
        @(posedge ref_clk);
        receive_mode <= 1'b1;
        pulse(NK, 8'h00);
        wait_for(3, 1'b1);
        pulse(SP, 8'h00);
        wait_for(2, 1'b1);
        check("rx_byte", rx_data_r, RD_BYTE);
        wait_for(1, 1'b0);
        check("nak_sent", {mst_ack, nak_pending_r, stop_pending_r}, 8'h04);
        @(posedge ref_clk);
        receive_mode <= 1'b0;
        controller_enable <= 1'b0;
        brg_reload <= 16'h0003;
        brg_counter_irq_enable <= 1'b1;
        repeat (12) @(negedge ref_clk);
        irq_cnt = 0;
        repeat (80) begin
            @(negedge ref_clk);
            irq_cnt += brg_irq_r;
        end
        check("brg_pulses", irq_cnt[7:0], 8'h14);
        stop_test();
    end
endmodule // testbench
`default_nettype wire

/* File: verilog/i2c_master_control_bits.v */
// Two-wire master: start, stop, not-acknowledge, flush, baud timer and input filters
// Summary of operation
// - Start request self-clears after the start is driven, or when disabled.
// - A start is issued only once a byte is present to send.
// - Start during a byte waits until that byte and its acknowledge finish.
// - With stop and start both pending after a byte, the stop goes out first.
// - Writing 0 cannot clear start or stop; disable clears both.
// - Stop goes out after the byte sent, or after a byte received.
// - Stop request clears after the stop is sent, or when disabled.
// - Baud timer interrupt bit pulses an interrupt each time the counter hits zero.
// - Transmit-empty interrupt is requested while enabled and the data register empty.
// - Not-acknowledge request answers the next received byte with a NAK, then clears.
// - Flush empties the data register and sets the transmit-empty flag.
// - Flush is a command only and always reads back 0.
// - Filter enable rejects input pulses shorter than two system clocks.
// - Filtered SDA and SCL lag the pins by three system clocks.
`include "i2c_ctl_defines.vh"
`default_nettype none

module i2c_master_control_bits #(
    parameter BRG_W = 16
) (
    input  wire             ref_clk,
    input  wire             rst_b,
    input  wire             clk_en,
    input  wire             controller_enable,
    input  wire             start_set,
    input  wire             stop_set,
    input  wire             nak_set,
    input  wire             flush_cmd,
    input  wire             brg_counter_irq_enable,
    input  wire             tx_empty_irq_enable,
    input  wire             input_glitch_filter_enable,
    input  wire             receive_mode,
    input  wire [BRG_W-1:0] brg_reload,
    input  wire             data_wr,
    input  wire [7:0]       data_in,
    input  wire             sda_in,
    input  wire             scl_in,
    output reg              sda_out_r,
    output reg              sda_oe_r,
    output reg              scl_out_r,
    output reg              scl_oe_r,
    output reg              start_pending_r,
    output reg              stop_pending_r,
    output reg              nak_pending_r,
    output reg              flush_readback_r,
    output reg              tx_data_empty_flag_r,
    output reg              tx_empty_irq_r,
    output reg              brg_irq_r,
    output reg  [7:0]       rx_data_r,
    output reg              rx_valid_r,
    output reg              ack_missing_r,
    output reg              bus_busy_r
);

    localparam [5:0] ST_IDLE  = 6'b00_0001;
    localparam [5:0] ST_START = 6'b00_0010;
    localparam [5:0] ST_BIT   = 6'b00_0100;
    localparam [5:0] ST_ACK   = 6'b00_1000;
    localparam [5:0] ST_STOP  = 6'b01_0000;
    localparam [5:0] ST_HOLD  = 6'b10_0000;

    reg  [5:0]       state_r;
    reg  [1:0]       phase_r;
    reg  [3:0]       bit_cnt_r;
    reg  [7:0]       shift_r;
    reg              rx_byte_r;
    reg  [7:0]       data_r;
    reg  [BRG_W-1:0] brg_cnt_r;
    reg  [1:0]       sync1_r;
    reg  [1:0]       sync2_r;
    reg  [1:0]       delay3_r;
    reg  [1:0]       held_r;
    wire [1:0]       pin_in;
    wire [1:0]       filt_line;
    wire [1:0]       line_in;
    wire             brg_zero;
    wire             scl_stretched;
    wire             step;
    wire             last_phase;
    wire             have_data;

    assign pin_in = {scl_in, sda_in};

    // Two-flop synchroniser, then a one-clock glitch filter per line
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_line
            always @(posedge ref_clk or negedge rst_b) begin
                if (!rst_b) begin
                    sync1_r[gi]  <= 1'b1;
                    sync2_r[gi]  <= 1'b1;
                    delay3_r[gi] <= 1'b1;
                    held_r[gi]   <= 1'b1;
                end else if (clk_en) begin
                    sync1_r[gi]  <= pin_in[gi];
                    sync2_r[gi]  <= sync1_r[gi];
                    delay3_r[gi] <= sync2_r[gi];
                    held_r[gi]   <= filt_line[gi];
                end
            end
            // A level must be seen on two successive clocks to pass
            assign filt_line[gi] = (sync2_r[gi] == delay3_r[gi]) ?
                                   delay3_r[gi] : held_r[gi];
        end
    endgenerate

    assign line_in = input_glitch_filter_enable ? filt_line : sync2_r;

    // Shared quarter-bit timer, also usable as a spare counter
    assign brg_zero = (brg_cnt_r == {BRG_W{1'b0}});

    // A slave holding SCL low stalls the phase after SCL is released
    assign scl_stretched = !scl_oe_r && !line_in[`I2C_SCL_IDX];
    assign step          = brg_zero && !scl_stretched;
    assign last_phase    = (phase_r == `I2C_LAST_PHASE);
    assign have_data     = !tx_data_empty_flag_r;

    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            brg_cnt_r <= `I2C_BRG_RST;
            brg_irq_r <= 1'b0;
        end else if (clk_en) begin
            brg_irq_r <= 1'b0;
            if (controller_enable || brg_counter_irq_enable) begin
                if (brg_zero) begin
                    brg_cnt_r <= brg_reload;
                    brg_irq_r <= brg_counter_irq_enable;
                end else begin
                    brg_cnt_r <= brg_cnt_r - {{(BRG_W-1){1'b0}}, 1'b1};
                end
            end else begin
                brg_cnt_r <= brg_reload;
            end
        end
    end

    // Decide what follows a finished acknowledge phase
    function [5:0] after_byte;
        input stop_p;
        input start_p;
        input data_p;
        input rx_p;
        begin
            if (stop_p) begin
                after_byte = ST_STOP;
            end else if (start_p && data_p) begin
                after_byte = ST_START;
            end else if (rx_p || data_p) begin
                after_byte = ST_BIT;
            end else begin
                after_byte = ST_HOLD;
            end
        end
    endfunction

    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_r              <= ST_IDLE;
            phase_r              <= 2'h0;
            bit_cnt_r            <= 4'h0;
            shift_r              <= `I2C_DATA_RST;
            rx_byte_r            <= 1'b0;
            data_r               <= `I2C_DATA_RST;
            sda_out_r            <= 1'b0;
            sda_oe_r             <= 1'b0;
            scl_out_r            <= 1'b0;
            scl_oe_r             <= 1'b0;
            start_pending_r      <= 1'b0;
            stop_pending_r       <= 1'b0;
            nak_pending_r        <= 1'b0;
            flush_readback_r     <= 1'b0;
            tx_data_empty_flag_r <= 1'b1;
            tx_empty_irq_r       <= 1'b0;
            rx_data_r            <= `I2C_DATA_RST;
            rx_valid_r           <= 1'b0;
            ack_missing_r        <= 1'b0;
            bus_busy_r           <= 1'b0;
        end else if (clk_en) begin
            rx_valid_r       <= 1'b0;
            flush_readback_r <= 1'b0;
            tx_empty_irq_r   <= tx_empty_irq_enable && controller_enable &&
                                tx_data_empty_flag_r;
            if (!controller_enable) begin
                // Disable drops every request and releases the bus
                state_r         <= ST_IDLE;
                phase_r         <= 2'h0;
                sda_oe_r        <= 1'b0;
                scl_oe_r        <= 1'b0;
                start_pending_r <= 1'b0;
                stop_pending_r  <= 1'b0;
                nak_pending_r   <= 1'b0;
                bus_busy_r      <= 1'b0;
                if (flush_cmd) begin
                    tx_data_empty_flag_r <= 1'b1;
                end
                if (data_wr) begin
                    data_r               <= data_in;
                    tx_data_empty_flag_r <= 1'b0;
                end
            end else begin
                // Data register: a write wins over flush and over a load
                if (flush_cmd) begin
                    tx_data_empty_flag_r <= 1'b1;
                end
                case (state_r)
                    ST_IDLE: begin
                        sda_oe_r   <= 1'b0;
                        scl_oe_r   <= 1'b0;
                        bus_busy_r <= 1'b0;
                        phase_r    <= 2'h0;
                        if (start_pending_r && have_data && !flush_cmd && brg_zero) begin
                            state_r    <= ST_START;
                            bus_busy_r <= 1'b1;
                        end
                    end
                    ST_START: begin
                        if (step) begin
                            phase_r <= phase_r + 2'h1;
                            case (phase_r)
                                2'h0: begin
                                    sda_oe_r <= 1'b0;
                                    scl_oe_r <= 1'b0;
                                end
                                2'h1: sda_oe_r <= 1'b1;
                                2'h2: scl_oe_r <= 1'b1;
                                default: begin
                                    // Start is on the wire: take the byte
                                    start_pending_r      <= 1'b0;
                                    shift_r              <= data_r;
                                    tx_data_empty_flag_r <= 1'b1;
                                    rx_byte_r            <= 1'b0;
                                    bit_cnt_r            <= 4'h0;
                                    state_r              <= ST_BIT;
                                end
                            endcase
                        end
                    end
                    ST_BIT: begin
                        if (step) begin
                            phase_r <= phase_r + 2'h1;
                            case (phase_r)
                                2'h0: sda_oe_r <= rx_byte_r ? 1'b0 : !shift_r[7];
                                2'h1: scl_oe_r <= 1'b0;
                                2'h2: begin
                                    if (rx_byte_r) begin
                                        shift_r <= {shift_r[6:0], line_in[`I2C_SDA_IDX]};
                                    end else begin
                                        shift_r <= {shift_r[6:0], 1'b0};
                                    end
                                    bit_cnt_r <= bit_cnt_r + 4'h1;
                                end
                                default: begin
                                    scl_oe_r <= 1'b1;
                                    if (bit_cnt_r == `I2C_BITS_PER_BYTE) begin
                                        state_r <= ST_ACK;
                                    end
                                end
                            endcase
                        end
                    end
                    ST_ACK: begin
                        if (step) begin
                            phase_r <= phase_r + 2'h1;
                            case (phase_r)
                                2'h0: sda_oe_r <= rx_byte_r && !nak_pending_r;
                                2'h1: scl_oe_r <= 1'b0;
                                2'h2: begin
                                    if (rx_byte_r) begin
                                        rx_data_r  <= shift_r;
                                        rx_valid_r <= 1'b1;
                                        if (nak_pending_r && !sda_oe_r) begin
                                            nak_pending_r <= 1'b0;
                                        end
                                    end else begin
                                        ack_missing_r <= line_in[`I2C_SDA_IDX];
                                    end
                                end
                                default: begin
                                    scl_oe_r  <= 1'b1;
                                    sda_oe_r  <= 1'b0;
                                    bit_cnt_r <= 4'h0;
                                    state_r   <= after_byte(stop_pending_r,
                                                 start_pending_r, have_data,
                                                 receive_mode);
                                    if (!stop_pending_r && !start_pending_r) begin
                                        rx_byte_r <= receive_mode;
                                        if (!receive_mode && have_data) begin
                                            shift_r              <= data_r;
                                            tx_data_empty_flag_r <= 1'b1;
                                        end
                                    end
                                end
                            endcase
                        end
                    end
                    ST_HOLD: begin
                        // SCL held low until there is something to do
                        phase_r <= 2'h0;
                        if (stop_pending_r) begin
                            state_r <= ST_STOP;
                        end else if (start_pending_r && have_data) begin
                            state_r <= ST_START;
                        end else if (have_data && !flush_cmd) begin
                            shift_r              <= data_r;
                            tx_data_empty_flag_r <= 1'b1;
                            rx_byte_r            <= 1'b0;
                            state_r              <= ST_BIT;
                        end
                    end
                    ST_STOP: begin
                        if (step) begin
                            phase_r <= phase_r + 2'h1;
                            case (phase_r)
                                2'h0: sda_oe_r <= 1'b1;
                                2'h1: scl_oe_r <= 1'b0;
                                2'h2: sda_oe_r <= 1'b0;
                                default: begin
                                    stop_pending_r <= 1'b0;
                                    state_r        <= ST_IDLE;
                                end
                            endcase
                        end
                    end
                    default: state_r <= ST_IDLE;
                endcase
                // Software sets win over the hardware clears above
                if (start_set) begin
                    start_pending_r <= 1'b1;
                end
                if (stop_set) begin
                    stop_pending_r <= 1'b1;
                end
                if (nak_set) begin
                    nak_pending_r <= 1'b1;
                end
                if (data_wr) begin
                    data_r               <= data_in;
                    tx_data_empty_flag_r <= 1'b0;
                end
            end
        end
    end

endmodule // i2c_master_control_bits

`default_nettype wire
